/* File: verilog/ee_target.sv */
// Summary of operation
// - SDA fall with SCL high starts commands.
// - SDA rise with SCL high stops; standby after.
// - Eight-bit words, target acks in ninth clock.
// - Controller recovers with nine clocks, then start.
// - Address word selects on three strap bits.
// - Address word last bit selects read/write.
// - Match acks; mismatch releases bus, goes idle.
// - Write protect high blocks main array programming.
// - Array is 512 pages of 128 bytes.
// - Byte write: two address bytes, data, stop.
// - Program cycle ignores inputs, within 3 ms.
// - Page write takes up to 127 more bytes.
// - Write address wraps within its page.
// - ID write uses type 1011, lock bit zero.
// - Locked ID page: write data bytes not acked.
// - Polling acks only after programming ends.
// - Counter holds last address plus one, wraps.
// - Current read returns byte at counter.
// - Random read: dummy write, repeated start, read.
// - Controller ack continues sequential read, increments.
// - ID read: type 1011, offset in low bits.
// - Lock command: lock bit one, data bit 1.
module ee_target #(
    parameter logic [ee_pkg::EE_TIMER_W-1:0] PROG_CYCLES =
        ee_pkg::EE_TIMER_W'(ee_pkg::EE_PROG_CYCLES)
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    ee_link_if.dev                          link,
    input  wire logic [ee_pkg::EE_CS_W-1:0] chip_select_strap_pins,
    input  wire logic                       write_protect,
    output      logic                       standby
);
    import ee_pkg::*;

    typedef struct packed {
        logic                    scl_s1;
        logic                    scl_s2;
        logic                    scl_d;
        logic                    sda_s1;
        logic                    sda_s2;
        logic                    sda_d;
        logic                    wp_s1;
        logic                    wp_s2;
        logic [EE_CS_W-1:0]      cs_s1;
        logic [EE_CS_W-1:0]      cs_s2;
        ee_dev_state_t           state;
        logic [3:0]              cnt;
        logic [7:0]              sr;
        logic [7:0]              dout;
        logic                    mack;
        logic                    is_id;
        logic [7:0]              hi;
        logic [EE_ADDR_W-1:0]    ptr;
        logic                    dirty;
        logic                    lock_pend;
        logic                    locked;
        logic [EE_TIMER_W-1:0]   timer;
        logic                    oe;
        logic                    standby;
    } ee_dev_reg_t;

    ee_dev_reg_t                 r;
    ee_dev_reg_t                 next_r;
    logic [7:0]                  mem [EE_MEM_BYTES];
    logic [7:0]                  idmem [EE_ID_BYTES];
    logic                        wr_mem;
    logic                        wr_id;
    logic [7:0]                  rd_byte;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_seen;
    logic                        stop_seen;
    logic                        busy;

    function automatic logic [EE_ADDR_W-1:0] page_inc(input logic [EE_ADDR_W-1:0] a);
        page_inc = {a[EE_ADDR_W-1:EE_OFS_W], EE_OFS_W'(a[EE_OFS_W-1:0] + 1'b1)};
    endfunction

    function automatic logic dev_match(input logic [7:0] w, input logic [EE_CS_W-1:0] cs);
        dev_match = (w[7:5] == EE_TYPE_PREFIX) && (w[3:1] == cs);
    endfunction

    assign scl_rise   = r.scl_s2 & ~r.scl_d;
    assign scl_fall   = ~r.scl_s2 & r.scl_d;
    assign start_seen = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    assign stop_seen  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    assign busy       = (r.timer != '0);
    assign rd_byte    = r.is_id ? idmem[r.ptr[EE_OFS_W-1:0]] : mem[r.ptr];

    always_comb
    begin
        next_r = r;
        wr_mem = 1'b0;
        wr_id  = 1'b0;
        next_r.scl_s1 = link.scl;
        next_r.scl_s2 = r.scl_s1;
        next_r.scl_d  = r.scl_s2;
        next_r.sda_s1 = link.sda;
        next_r.sda_s2 = r.sda_s1;
        next_r.sda_d  = r.sda_s2;
        next_r.wp_s1  = write_protect;
        next_r.wp_s2  = r.wp_s1;
        next_r.cs_s1  = chip_select_strap_pins;
        next_r.cs_s2  = r.cs_s1;
        if (busy)
        begin
            next_r.timer = r.timer - 1'b1;
        end
        if (start_seen)
        begin
            next_r.state = EE_D_DEVADDR;
            // The SCL fall that follows a start wraps this count to bit zero.
            next_r.cnt   = '1;
            next_r.oe    = 1'b0;
        end
        else if (stop_seen)
        begin
            next_r.state = EE_D_IDLE;
            next_r.oe    = 1'b0;
            if (r.dirty | r.lock_pend)
            begin
                next_r.timer     = PROG_CYCLES;
                next_r.locked    = r.locked | r.lock_pend;
                next_r.dirty     = 1'b0;
                next_r.lock_pend = 1'b0;
            end
        end
        else if (r.state != EE_D_IDLE && scl_rise)
        begin
            if (r.cnt < EE_ACK_BIT)
            begin
                next_r.sr = {r.sr[6:0], r.sda_s2};
            end
            else
            begin
                next_r.mack = r.sda_s2;
            end
        end
        else if (r.state != EE_D_IDLE && scl_fall)
        begin
            if (r.cnt == EE_LAST_BIT)
            begin
                next_r.cnt = EE_ACK_BIT;
                next_r.oe  = 1'b1;
                case (r.state)
                    EE_D_DEVADDR:
                    begin
                        if (dev_match(r.sr, r.cs_s2) && !busy)
                        begin
                            next_r.is_id = r.sr[EE_TYPE_ID_BIT];
                            next_r.mack  = 1'b0;
                            next_r.state = r.sr[0] ? EE_D_RDATA : EE_D_ADDR_HI;
                        end
                        else
                        begin
                            next_r.oe    = 1'b0;
                            next_r.state = EE_D_IDLE;
                        end
                    end
                    EE_D_ADDR_HI:
                    begin
                        next_r.hi    = r.sr;
                        next_r.state = EE_D_ADDR_LO;
                    end
                    EE_D_ADDR_LO:
                    begin
                        next_r.ptr   = {r.hi, r.sr};
                        next_r.state = EE_D_WDATA;
                    end
                    EE_D_WDATA:
                    begin
                        if (r.is_id && r.hi[EE_ID_LOCK_BIT])
                        begin
                            if (r.sr[EE_LOCK_DAT_BIT])
                            begin
                                next_r.lock_pend = 1'b1;
                            end
                        end
                        else if (r.is_id && r.locked)
                        begin
                            next_r.oe    = 1'b0;
                            next_r.state = EE_D_IDLE;
                        end
                        else if (r.is_id)
                        begin
                            wr_id        = 1'b1;
                            next_r.dirty = 1'b1;
                            next_r.ptr   = page_inc(r.ptr);
                        end
                        else
                        begin
                            wr_mem       = ~r.wp_s2;
                            next_r.dirty = r.dirty | ~r.wp_s2;
                            next_r.ptr   = page_inc(r.ptr);
                        end
                    end
                    EE_D_RDATA:
                    begin
                        next_r.oe = 1'b0;
                    end
                    default:
                    begin
                        next_r.oe    = 1'b0;
                        next_r.state = EE_D_IDLE;
                    end
                endcase
            end
            else if (r.cnt == EE_ACK_BIT)
            begin
                next_r.cnt = '0;
                next_r.oe  = 1'b0;
                if (r.state == EE_D_RDATA)
                begin
                    if (!r.mack)
                    begin
                        next_r.dout = rd_byte;
                        next_r.oe   = ~rd_byte[7];
                        next_r.ptr  = r.is_id ? page_inc(r.ptr) : r.ptr + 1'b1;
                    end
                    else
                    begin
                        next_r.state = EE_D_IDLE;
                    end
                end
            end
            else
            begin
                next_r.cnt = r.cnt + 1'b1;
                if (r.state == EE_D_RDATA)
                begin
                    next_r.dout = {r.dout[6:0], 1'b0};
                    next_r.oe   = ~r.dout[6];
                end
            end
        end
        next_r.standby = (next_r.state == EE_D_IDLE) && (next_r.timer == '0);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '{state: EE_D_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, standby: 1'b1,
                   mack: 1'b1, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_mem)
        begin
            mem[r.ptr] <= r.sr;
        end
        if (wr_id)
        begin
            idmem[r.ptr[EE_OFS_W-1:0]] <= r.sr;
        end
    end

    assign link.sda_dev_oe = r.oe;
    assign standby         = r.standby;
endmodule

/* File: verilog/ee_pkg.sv */
package ee_pkg;
    localparam int          EE_ADDR_W      = 16;
    localparam int          EE_OFS_W       = 7;
    localparam int          EE_MEM_BYTES   = 65536;
    localparam int          EE_ID_BYTES    = 128;
    localparam int          EE_CS_W        = 3;
    localparam logic [2:0]  EE_TYPE_PREFIX = 3'h5;
    localparam int          EE_TYPE_ID_BIT = 4;
    localparam int          EE_ID_LOCK_BIT = 2;
    localparam int          EE_LOCK_DAT_BIT = 1;
    localparam logic [3:0]  EE_LAST_BIT    = 4'h7;
    localparam logic [3:0]  EE_ACK_BIT     = 4'h8;
    localparam int          EE_CLK_NS      = 4;
    localparam int          EE_PROG_TIME_NS = 3000000;
    localparam int          EE_PROG_CYCLES = EE_PROG_TIME_NS / EE_CLK_NS;
    localparam int          EE_TIMER_W     = 20;
    localparam int          EE_SCL_HALF_NS = 500;
    localparam int          EE_HALF_CYCLES = EE_SCL_HALF_NS / EE_CLK_NS;
    localparam int          EE_DIV_W       = 8;
    localparam logic [3:0]  EE_REG_CTRL    = 4'h0;
    localparam logic [3:0]  EE_REG_STATUS  = 4'h4;
    localparam int          EE_REG_AW      = 4;
    localparam logic [2:0]  EE_CMD_START   = 3'h1;
    localparam logic [2:0]  EE_CMD_STOP    = 3'h2;
    localparam logic [2:0]  EE_CMD_WRITE   = 3'h3;
    localparam logic [2:0]  EE_CMD_READ    = 3'h4;
    localparam logic [2:0]  EE_CMD_RECOVER = 3'h5;
    localparam int          EE_CTRL_NACK_BIT = 3;
    localparam int          EE_DATA_LSB    = 8;

    typedef enum logic [2:0] {
        EE_D_IDLE    = 3'h0,
        EE_D_DEVADDR = 3'h1,
        EE_D_ADDR_HI = 3'h2,
        EE_D_ADDR_LO = 3'h3,
        EE_D_WDATA   = 3'h4,
        EE_D_RDATA   = 3'h5
    } ee_dev_state_t;

    typedef enum logic [1:0] {
        EE_H_IDLE  = 2'h0,
        EE_H_START = 2'h1,
        EE_H_STOP  = 2'h2,
        EE_H_BYTE  = 2'h3
    } ee_host_state_t;
endpackage

/* File: verilog/ee_link_if.sv */
interface ee_link_if;
    logic scl;
    logic sda_dev_oe;
    logic sda_host_oe;
    logic sda;

    // Open-drain wire: low whenever either end drives.
    assign sda = ~(sda_dev_oe | sda_host_oe);

    modport dev (input scl, input sda, output sda_dev_oe);
    modport host (output scl, output sda_host_oe, input sda);
endinterface

/* File: verilog/ee_controller.sv */
module ee_controller (
    input  wire logic                        clk,
    input  wire logic                        rst,
    ee_link_if.host                          link,
    input  wire logic [ee_pkg::EE_REG_AW-1:0] reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output      logic [31:0]                 reg_rdata
);
    import ee_pkg::*;

    typedef struct packed {
        logic                  sda_s1;
        logic                  sda_s2;
        ee_host_state_t        state;
        logic [1:0]            step;
        logic [3:0]            bitn;
        logic [EE_DIV_W-1:0]   div;
        logic                  scl;
        logic                  oe;
        logic [7:0]            sh;
        logic                  rd_mode;
        logic                  nack;
        logic                  acked;
        logic [7:0]            rx;
        logic                  chain_start;
        logic [31:0]           rdata;
    } ee_host_reg_t;

    ee_host_reg_t              r;
    ee_host_reg_t              next_r;
    logic                      tick;
    logic [2:0]                cmd;

    assign tick = (r.div == '0);
    assign cmd  = reg_wdata[2:0];

    always_comb
    begin
        next_r = r;
        next_r.sda_s1 = link.sda;
        next_r.sda_s2 = r.sda_s1;
        next_r.rdata  = '0;
        next_r.div    = tick ? EE_DIV_W'(EE_HALF_CYCLES - 1) : r.div - 1'b1;
        if (reg_read && reg_addr == EE_REG_STATUS)
        begin
            next_r.rdata = {16'h0, r.rx, 6'h0, r.acked, r.state != EE_H_IDLE};
        end
        if (reg_write && reg_addr == EE_REG_CTRL && r.state == EE_H_IDLE)
        begin
            next_r.step        = '0;
            next_r.bitn        = '0;
            next_r.chain_start = 1'b0;
            next_r.sh          = reg_wdata[EE_DATA_LSB +: 8];
            next_r.nack        = reg_wdata[EE_CTRL_NACK_BIT];
            case (cmd)
                EE_CMD_START:   next_r.state = EE_H_START;
                EE_CMD_STOP:    next_r.state = EE_H_STOP;
                EE_CMD_WRITE:
                begin
                    next_r.state   = EE_H_BYTE;
                    next_r.rd_mode = 1'b0;
                end
                EE_CMD_READ:
                begin
                    next_r.state   = EE_H_BYTE;
                    next_r.rd_mode = 1'b1;
                end
                EE_CMD_RECOVER:
                begin
                    next_r.state       = EE_H_BYTE;
                    next_r.rd_mode     = 1'b1;
                    next_r.nack        = 1'b1;
                    next_r.chain_start = 1'b1;
                end
                default:        next_r.state = EE_H_IDLE;
            endcase
        end
        else if (tick)
        begin
            case (r.state)
                EE_H_START:
                begin
                    next_r.step = r.step + 1'b1;
                    case (r.step)
                        2'h0: next_r.oe  = 1'b0;
                        2'h1: next_r.scl = 1'b1;
                        2'h2: next_r.oe  = 1'b1;
                        default:
                        begin
                            next_r.scl   = 1'b0;
                            next_r.state = EE_H_IDLE;
                        end
                    endcase
                end
                EE_H_STOP:
                begin
                    next_r.step = r.step + 1'b1;
                    case (r.step)
                        2'h0: next_r.oe  = 1'b1;
                        2'h1: next_r.scl = 1'b1;
                        default:
                        begin
                            next_r.oe    = 1'b0;
                            next_r.state = EE_H_IDLE;
                        end
                    endcase
                end
                EE_H_BYTE:
                begin
                    case (r.step)
                        2'h0:
                        begin
                            if (r.bitn == EE_ACK_BIT)
                            begin
                                next_r.oe = r.rd_mode & ~r.nack;
                            end
                            else
                            begin
                                next_r.oe = ~r.rd_mode & ~r.sh[7];
                            end
                            next_r.step = 2'h1;
                        end
                        2'h1:
                        begin
                            next_r.scl  = 1'b1;
                            next_r.step = 2'h2;
                        end
                        default:
                        begin
                            next_r.scl  = 1'b0;
                            next_r.step = 2'h0;
                            next_r.bitn = r.bitn + 1'b1;
                            if (r.bitn == EE_ACK_BIT)
                            begin
                                next_r.acked = r.rd_mode ? r.acked : ~r.sda_s2;
                                next_r.rx    = r.sh;
                                next_r.state = r.chain_start ? EE_H_START : EE_H_IDLE;
                                next_r.bitn  = '0;
                            end
                            else
                            begin
                                next_r.sh = {r.sh[6:0], r.sda_s2};
                            end
                        end
                    endcase
                end
                default:
                begin
                    next_r.state = EE_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '{state: EE_H_IDLE, sda_s1: 1'b1, sda_s2: 1'b1, scl: 1'b1, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign link.scl         = r.scl;
    assign link.sda_host_oe = r.oe;
    assign reg_rdata        = r.rdata;
endmodule

/* File: dv/ee_link_sva.sv */
module ee_link_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_dev_oe,
    input wire logic sda_host_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       scl_q;
    logic       sda_q;
    logic       in_frame;
    logic       rw;
    logic [3:0] bit_idx;
    logic [1:0] byte_idx;
    logic       nacked;
    wire        rise     = scl && !scl_q;
    wire        start_ev = scl && scl_q && sda_q && !sda;
    wire        stop_ev  = scl && scl_q && !sda_q && sda;

    // Tracks frame, bit slot and direction as seen on the wire.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            in_frame <= 1'b0;
            rw       <= 1'b0;
            bit_idx  <= 4'h0;
            byte_idx <= 2'h0;
            nacked   <= 1'b0;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev)
            begin
                in_frame <= 1'b1;
                bit_idx  <= 4'h0;
                byte_idx <= 2'h0;
                nacked   <= 1'b0;
            end
            else if (stop_ev)
                in_frame <= 1'b0;
            else if (rise)
            begin
                bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                if (bit_idx == 4'h8 && byte_idx != 2'h3)
                    byte_idx <= byte_idx + 2'h1;
                if (bit_idx == 4'h7 && byte_idx == 2'h0)
                    rw <= sda;
                if (bit_idx == 4'h8 && sda)
                    nacked <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    addr_quiet_a:
        assert property (in_frame && rise && byte_idx == 2'h0 && bit_idx != 4'h8 |-> !sda_dev_oe)
        else $error("target drove SDA inside the address word");
    write_quiet_a:
        assert property (in_frame && rise && !rw && bit_idx != 4'h8 |-> !sda_dev_oe)
        else $error("target drove SDA on a data bit of a write");
    read_ack_slot_a:
        assert property (in_frame && rise && rw && byte_idx != 2'h0 && bit_idx == 4'h8
            |-> !sda_dev_oe)
        else $error("target drove SDA in the controller acknowledge slot");
    host_ack_free_a:
        assert property (in_frame && rise && bit_idx == 4'h8 && (!rw || byte_idx == 2'h0)
            |-> !sda_host_oe)
        else $error("controller held SDA in the target acknowledge slot");
    host_read_free_a:
        assert property (in_frame && rise && rw && byte_idx != 2'h0 && bit_idx != 4'h8
            && !nacked |-> !sda_host_oe)
        else $error("controller held SDA on a read data bit");
    dev_edge_low_a:
        assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("target changed SDA while SCL was high");
    start_release_a:
        assert property (start_ev |-> !sda_dev_oe [*8])
        else $error("target drove SDA right after a start");
    stop_release_a:
        assert property (stop_ev |-> !sda_dev_oe [*8])
        else $error("target drove SDA right after a stop");
    idle_quiet_a:
        assert property (!in_frame |-> !sda_dev_oe)
        else $error("target drove SDA outside a frame");
endmodule

/* File: dv/i2c_serial_eeprom_target_tb_top.sv */
module i2c_serial_eeprom_target_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ee_pkg::*;
    localparam logic [EE_TIMER_W-1:0] PROG = 20'h00fa0;
    localparam logic [2:0]            CS   = 3'h5;
    localparam logic [7:0]            DW   = {4'ha, CS, 1'b0};
    localparam logic [7:0]            DR   = {4'ha, CS, 1'b1};
    localparam logic [7:0]            IW   = {4'hb, CS, 1'b0};
    localparam logic [7:0]            IR   = {4'hb, CS, 1'b1};
    logic        clk           = 1'b0;
    logic        rst           = 1'b1;
    logic        write_protect = 1'b0;
    logic [3:0]  reg_addr      = 4'h0;
    logic [31:0] reg_wdata     = 32'h0;
    logic        reg_write     = 1'b0;
    logic        reg_read      = 1'b0;
    logic [31:0] reg_rdata;
    logic        standby;
    int          num_errors    = 0;
    int          num_checks    = 0;

    ee_link_if lk ();
    ee_target #(.PROG_CYCLES(PROG)) i_ee_target (.clk(clk), .rst(rst), .link(lk),
        .chip_select_strap_pins(CS), .write_protect(write_protect), .standby(standby));
    ee_controller i_ee_controller (.clk(clk), .rst(rst), .link(lk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));
    ee_link_sva i_ee_link_sva (.clk(clk), .rst(rst), .scl(lk.scl), .sda(lk.sda),
        .sda_dev_oe(lk.sda_dev_oe), .sda_host_oe(lk.sda_host_oe));

    always #2 clk = ~clk;

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic op(input logic [3:0] c, input logic [7:0] b, output logic [31:0] s);
        int n;
        @(posedge clk);
        reg_addr <= EE_REG_CTRL;
        reg_wdata <= {16'h0, b, 4'h0, c};
        reg_write <= 1'b1;
        s = 32'h1;
        n = 0;
        @(posedge clk);
        reg_write <= 1'b0;
        while (s[0] !== 1'b0 && n < 9000)
        begin
            rd(EE_REG_STATUS, s);
            n++;
        end
        chk({7'h0, s[0]}, 8'h0);
    endtask

    task automatic cmd(input logic [2:0] c);
        logic [31:0] s;
        op({1'b0, c}, 8'h0, s);
    endtask

    task automatic wb(input logic [7:0] b, input logic a);
        logic [31:0] s;
        op({1'b0, EE_CMD_WRITE}, b, s);
        chk({7'h0, s[1]}, {7'h0, a});
    endtask

    task automatic rb(input logic nk, input logic [7:0] e);
        logic [31:0] s;
        op({nk, EE_CMD_READ}, 8'h0, s);
        chk(s[15:8], e);
    endtask

    initial
    begin
        #700000;
        num_errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        close_out();
    end

    initial
    begin
        logic [31:0] s;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk({7'h0, standby}, 8'h1);
        rd(EE_REG_STATUS, s);
        chk(s[7:0], 8'h0);
        rd(4'h8, s);
        chk(s[7:0], 8'h0);
        cmd(EE_CMD_RECOVER);
        wb(DW, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'hff, 1'b1);
        wb(8'h11, 1'b1);
        wb(8'h22, 1'b1);
        wb(8'h33, 1'b1);
        cmd(EE_CMD_STOP);
        repeat (4) @(posedge clk);
        #1 chk({7'h0, standby}, 8'h0);
        cmd(EE_CMD_START);
        wb(DW, 1'b0);
        cmd(EE_CMD_STOP);
        cmd(EE_CMD_START);
        wb(IW, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h05, 1'b1);
        wb(8'h5a, 1'b1);
        cmd(EE_CMD_STOP);
        repeat (PROG + 8) @(posedge clk);
        #1 chk({7'h0, standby}, 8'h1);
        cmd(EE_CMD_START);
        wb({4'ha, CS ^ 3'h1, 1'b0}, 1'b0);
        cmd(EE_CMD_STOP);
        @(posedge clk);
        write_protect <= 1'b1;
        cmd(EE_CMD_START);
        wb(DW, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h80, 1'b1);
        wb(8'hc3, 1'b1);
        cmd(EE_CMD_STOP);
        @(posedge clk);
        write_protect <= 1'b0;
        cmd(EE_CMD_START);
        wb(DW, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h80, 1'b1);
        cmd(EE_CMD_START);
        wb(DR, 1'b1);
        rb(1'b0, 8'h22);
        rb(1'b1, 8'h33);
        cmd(EE_CMD_STOP);
        cmd(EE_CMD_START);
        wb(IW, 1'b1);
        wb(8'h04, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h02, 1'b1);
        cmd(EE_CMD_STOP);
        repeat (PROG) @(posedge clk);
        cmd(EE_CMD_START);
        wb(IW, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h05, 1'b1);
        wb(8'h77, 1'b0);
        cmd(EE_CMD_START);
        wb(IR, 1'b1);
        rb(1'b1, 8'h5a);
        cmd(EE_CMD_STOP);
        close_out();
    end
endmodule
